// >>> src/motion_step_pkg.sv
// Purpose: Shared constants and types for the motion step trigger block
// Assumes: 250 MHz system clock, AXI4-Lite register access
// Notes:   Every offset, field code, reset value and timing count lives here

package motion_step_pkg;

  // ************************************************************
  // Register map (byte addresses; word numbers within a group block)
  // ************************************************************
  localparam int          ADDR_W        = 8;
  localparam logic [7:0]  CTRL_OFS      = 8'h00;  // Start / stop strobes
  localparam logic [7:0]  STATUS_OFS    = 8'h04;  // Busy and active group
  localparam logic [7:0]  GROUP_BASE    = 8'h10;  // First group block
  localparam logic [7:0]  GROUP_STRIDE  = 8'h10;  // One block per group
  localparam logic [1:0]  KIND_WORD     = 2'h0;   // group_kind_setting
  localparam logic [1:0]  PROP_WORD     = 2'h1;   // step_condition_property
  localparam logic [1:0]  VALUE_WORD    = 2'h2;   // step_condition_one_value

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int CTRL_START_BIT   = 0;
  localparam int CTRL_STOP_BIT    = 1;
  localparam int STATUS_BUSY_BIT  = 0;
  localparam int STATUS_GROUP_LSB = 8;

  // ************************************************************
  // Codes
  // ************************************************************
  localparam logic [1:0]  KIND_UNUSED   = 2'h0;
  localparam logic [1:0]  KIND_ABSOLUTE = 2'h1;
  localparam logic [1:0]  KIND_RELATIVE = 2'h2;
  localparam logic [3:0]  COND_UNCOND   = 4'h0;
  localparam logic [3:0]  COND_DELAY    = 4'h1;
  localparam logic [3:0]  COND_EDGE     = 4'h2;
  localparam logic [3:0]  COND_LEVEL    = 4'h3;
  localparam logic [15:0] EDGE_RISE     = 16'h0000;
  localparam logic [15:0] EDGE_FALL     = 16'h0001;
  localparam logic [15:0] EDGE_BOTH     = 16'h0002;
  localparam logic [15:0] LEVEL_HIGH    = 16'h0003;
  localparam logic [15:0] LEVEL_LOW     = 16'h0004;

  // ************************************************************
  // Reset values and bus answers
  // ************************************************************
  localparam logic [1:0]  KIND_RESET    = 2'h0;
  localparam logic [3:0]  PROP_RESET    = 4'h0;
  localparam logic [15:0] VALUE_RESET   = 16'h0000;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int MS_TIME_NS    = 1000000;  // One delay unit
  localparam int CLK_PERIOD_NS = 4;        // 250 MHz
  // Least time, so round up
  localparam int TICK_CYCLES   = (MS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ************************************************************
  // Types
  // ************************************************************
  typedef struct packed {
    logic [1:0]  kind;        // Group kind code
    logic [3:0]  cond_type;   // Step condition type
    logic [15:0] cond_value;  // Step condition value
  } group_cfg_type;

  typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_WAIT} seq_state_type;

endpackage

// >>> src/step_condition_check.sv
// Purpose: Evaluates the step condition of the active data group
// Assumes: position_step_input synchronous to sys_clk
// Notes:   arm restarts the millisecond divider and the delay count

`timescale 1ns/1ps

module step_condition_check
  import motion_step_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES
)(
  input  wire logic          sys_clk,
  input  wire logic          reset,
  input  wire logic          arm,
  input  wire group_cfg_type cfg,
  input  wire logic          position_step_input,
  output logic               cond_met
);

  localparam int DIV_W = $clog2(TICK_CYCLES_P + 1);

  logic [DIV_W-1:0] div_cnt;       // Cycles into current ms
  logic [DIV_W-1:0] next_div_cnt;
  logic [15:0]      elapsed;       // Whole ms since arm
  logic [15:0]      next_elapsed;
  logic             step_prev;     // Input one cycle ago
  logic             rise;
  logic             fall;
  logic [47:0]      since_arm;     // Cycles since arm, for checks only
  logic [47:0]      next_since_arm;

  // ************************************************************
  // Divider and delay count
  // ************************************************************
  // Divider restarts on arm so each delay starts on a full ms
  always_comb
  begin
    next_div_cnt   = div_cnt + 1'b1;
    next_elapsed   = elapsed;
    // Wide enough never to wrap within the longest delay
    next_since_arm = since_arm + 48'h1;
    if (arm)
    begin
      next_div_cnt   = '0;
      next_elapsed   = 16'h0000;
      next_since_arm = '0;
    end
    else if (div_cnt == DIV_W'(TICK_CYCLES_P - 1))
    begin
      next_div_cnt = '0;
      // Saturate, the longest delay fits exactly
      if (elapsed != 16'hffff)
        next_elapsed = elapsed + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      div_cnt   <= '0;
      elapsed   <= 16'h0000;
      step_prev <= 1'b0;
      since_arm <= '0;
    end
    else
    begin
      div_cnt   <= next_div_cnt;
      elapsed   <= next_elapsed;
      step_prev <= position_step_input;
      since_arm <= next_since_arm;
    end
  end

  assign rise = position_step_input & ~step_prev;
  assign fall = ~position_step_input & step_prev;

  // ************************************************************
  // Condition decode
  // ************************************************************
  // Unknown types or values never fire, so a bad setting just halts
  always_comb
  begin
    cond_met = 1'b0;
    case (cfg.cond_type)
      // R1: value ignored
      COND_UNCOND: cond_met = 1'b1;
      // R2: whole ms waited
      COND_DELAY:  cond_met = (elapsed >= cfg.cond_value);
      COND_EDGE:
      begin
        case (cfg.cond_value)
          // R3: rising edge only
          EDGE_RISE: cond_met = rise;
          // R4: falling edge only
          EDGE_FALL: cond_met = fall;
          // R5: either edge
          EDGE_BOTH: cond_met = rise | fall;
          default:   cond_met = 1'b0;
        endcase
      end
      COND_LEVEL:
      begin
        case (cfg.cond_value)
          // R6: high level
          LEVEL_HIGH: cond_met = position_step_input;
          // R7: low level
          LEVEL_LOW:  cond_met = ~position_step_input;
          default:    cond_met = 1'b0;
        endcase
      end
      default: cond_met = 1'b0;
    endcase
  end

  // ************************************************************
  // Checks
  // ************************************************************
  AST_UNCOND: assert property (@(posedge sys_clk) disable iff (reset)  // R1
    cfg.cond_type == COND_UNCOND |-> cond_met)
    else $error("Unconditional step did not fire");
  AST_DELAY: assert property (@(posedge sys_clk) disable iff (reset)  // R2
    cfg.cond_type == COND_DELAY
    |-> cond_met == (since_arm >= 48'(cfg.cond_value) * 48'(TICK_CYCLES_P)))
    else $error("Delay step fired at wrong time");
  AST_RISE: assert property (@(posedge sys_clk) disable iff (reset)  // R3
    cfg.cond_type == COND_EDGE && cfg.cond_value == EDGE_RISE
    |-> cond_met == (position_step_input && !$past(position_step_input)))
    else $error("Rising edge step wrong");
  AST_FALL: assert property (@(posedge sys_clk) disable iff (reset)  // R4
    cfg.cond_type == COND_EDGE && cfg.cond_value == EDGE_FALL
    |-> cond_met == (!position_step_input && $past(position_step_input)))
    else $error("Falling edge step wrong");
  AST_BOTH: assert property (@(posedge sys_clk) disable iff (reset)  // R5
    cfg.cond_type == COND_EDGE && cfg.cond_value == EDGE_BOTH
    |-> cond_met == $changed(position_step_input))
    else $error("Either edge step wrong");
  AST_HIGH: assert property (@(posedge sys_clk) disable iff (reset)  // R6
    cfg.cond_type == COND_LEVEL && cfg.cond_value == LEVEL_HIGH
    |-> cond_met == position_step_input)
    else $error("High level step wrong");
  AST_LOW: assert property (@(posedge sys_clk) disable iff (reset)  // R7
    cfg.cond_type == COND_LEVEL && cfg.cond_value == LEVEL_LOW
    |-> cond_met == !position_step_input)
    else $error("Low level step wrong");

endmodule // step_condition_check

// >>> src/motion_step_trigger.sv
// Purpose: Data group sequencer with step change trigger, AXI4-Lite regs
// Assumes: Single 250 MHz clock, position_step_input already synchronous
// Notes:   Sequence runs groups in order until an unused group or the last
//
// Local design decisions: the register offsets and the AXI4-Lite interface to the registers.

`timescale 1ns/1ps

// Functional notes
// R1: Unconditional step ignores value, fires at once
// R2: Delay step waits value milliseconds first
// R3: Edge value 0 fires on rising edge
// R4: Edge value 1 fires on falling edge
// R5: Edge value 2 fires on either edge
// R6: Level value 3 met while input high
// R7: Level value 4 met while input low
// R8: Group kind: unused, absolute, relative
// R9: Met condition advances to next group's motion
module motion_step_trigger
  import motion_step_pkg::*;
#(
  parameter int NUM_GROUPS    = 4,
  parameter int GROUP_W       = 2,
  parameter int TICK_CYCLES_P = TICK_CYCLES
)(
  input  wire logic              sys_clk,
  input  wire logic              reset,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              position_step_input,
  output logic                   motion_start,
  output logic [GROUP_W-1:0]     motion_group,
  output logic                   motion_relative
);

  // ************************************************************
  // Declarations
  // ************************************************************
  group_cfg_type        cfg [NUM_GROUPS];       // Per group settings
  group_cfg_type        next_cfg [NUM_GROUPS];
  logic                 aw_held, next_aw_held;  // Write address captured
  logic [ADDR_W-1:0]    aw_addr, next_aw_addr;
  logic                 w_held, next_w_held;    // Write data captured
  logic [31:0]          w_data, next_w_data;
  logic [3:0]           w_strb, next_w_strb;
  logic                 next_bvalid;
  logic [1:0]           next_bresp;
  logic                 next_rvalid;
  logic [31:0]          next_rdata;
  logic [1:0]           next_rresp;
  logic                 wr_go;                  // Write commits this cycle
  logic                 start_req;              // Ctrl start strobe
  logic                 stop_req;               // Ctrl stop strobe
  seq_state_type        state, next_state;
  logic [GROUP_W-1:0]   grp, next_grp;          // Active group
  logic                 next_motion_start;
  logic [GROUP_W-1:0]   next_motion_group;
  logic                 next_motion_relative;
  logic                 cond_met;               // Active condition holds

  // Merge byte lanes into an old word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++)
      if (strb[b])
        res[8*b +: 8] = nw[8*b +: 8];
    return res;
  endfunction

  // Group index of an address, NUM_GROUPS when not in a group block or on its unmapped word 3
  function automatic int group_of(input logic [ADDR_W-1:0] a);
    int idx;
    idx = int'(a[ADDR_W-1:4]) - int'(GROUP_BASE[ADDR_W-1:4]);
    if (a < GROUP_BASE || idx >= NUM_GROUPS || a[3:2] == 2'h3)
      idx = NUM_GROUPS;
    return idx;
  endfunction

  // ************************************************************
  // AXI4-Lite write channel
  // ************************************************************
  // Address and data may arrive in either order; each is held
  always_comb
  begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held  = w_held;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready)
      next_bvalid = 1'b0;
    if (wr_go)
    begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = (aw_addr == CTRL_OFS || group_of(aw_addr) < NUM_GROUPS) ? RESP_OKAY : RESP_SLVERR;
    end
  end

  assign s_axi_awready = ~aw_held;
  assign s_axi_wready  = ~w_held;
  assign wr_go         = aw_held & w_held & ~s_axi_bvalid;
  assign start_req     = wr_go && aw_addr == CTRL_OFS && w_strb[0] && w_data[CTRL_START_BIT];
  assign stop_req      = wr_go && aw_addr == CTRL_OFS && w_strb[0] && w_data[CTRL_STOP_BIT];

  // ************************************************************
  // Group settings, one block per group
  // ************************************************************
  for (genvar g = 0; g < NUM_GROUPS; g++)
  begin : g_cfg
    // Byte enables respected; narrow fields take the low bits
    always_comb
    begin
      logic [31:0] word;
      word        = 32'h0000_0000;
      next_cfg[g] = cfg[g];
      if (wr_go && group_of(aw_addr) == g)
      begin
        case (aw_addr[3:2])
          KIND_WORD:
          begin
            word             = merge({30'h0, cfg[g].kind}, w_data, w_strb);
            next_cfg[g].kind = word[1:0];
          end
          PROP_WORD:
          begin
            word                  = merge({28'h0, cfg[g].cond_type}, w_data, w_strb);
            next_cfg[g].cond_type = word[3:0];
          end
          VALUE_WORD:
          begin
            word                   = merge({16'h0, cfg[g].cond_value}, w_data, w_strb);
            next_cfg[g].cond_value = word[15:0];
          end
          default: next_cfg[g] = cfg[g];
        endcase
      end
    end

    always_ff @(posedge sys_clk or posedge reset)
    begin
      if (reset)
        cfg[g] <= '{kind: KIND_RESET, cond_type: PROP_RESET, cond_value: VALUE_RESET};
      else
        cfg[g] <= next_cfg[g];
    end
  end

  // ************************************************************
  // AXI4-Lite read channel
  // ************************************************************
  // One read at a time; arready drops while the answer waits
  always_comb
  begin
    next_rvalid = s_axi_rvalid;
    next_rdata  = s_axi_rdata;
    next_rresp  = s_axi_rresp;
    if (s_axi_rvalid && s_axi_rready)
      next_rvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_rvalid = 1'b1;
      next_rdata  = 32'h0000_0000;
      next_rresp  = RESP_OKAY;
      if (s_axi_araddr == CTRL_OFS)
        next_rdata = 32'h0000_0000;  // Strobes read as zero
      else if (s_axi_araddr == STATUS_OFS)
      begin
        next_rdata[STATUS_BUSY_BIT]                       = (state != ST_IDLE);
        next_rdata[STATUS_GROUP_LSB +: GROUP_W]           = grp;
      end
      else if (group_of(s_axi_araddr) < NUM_GROUPS)
      begin
        case (s_axi_araddr[3:2])
          KIND_WORD:  next_rdata[1:0]  = cfg[group_of(s_axi_araddr)].kind;
          PROP_WORD:  next_rdata[3:0]  = cfg[group_of(s_axi_araddr)].cond_type;
          VALUE_WORD: next_rdata[15:0] = cfg[group_of(s_axi_araddr)].cond_value;
          default:    next_rresp       = RESP_SLVERR;
        endcase
      end
      else
        next_rresp = RESP_SLVERR;
    end
  end

  assign s_axi_arready = ~s_axi_rvalid;

  // Bus registers
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      aw_held      <= 1'b0;
      aw_addr      <= '0;
      w_held       <= 1'b0;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end
    else
    begin
      aw_held      <= next_aw_held;
      aw_addr      <= next_aw_addr;
      w_held       <= next_w_held;
      w_data       <= next_w_data;
      w_strb       <= next_w_strb;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp  <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= next_rresp;
    end
  end

  // ************************************************************
  // Condition evaluation and sequencer
  // ************************************************************
  step_condition_check #(
    .TICK_CYCLES_P       (TICK_CYCLES_P)
  ) u_check (
    .sys_clk             (sys_clk),
    .reset               (reset),
    .arm                 (state == ST_LOAD),
    .cfg                 (cfg[grp]),
    .position_step_input (position_step_input),
    .cond_met            (cond_met)
  );
  // Stop wins over every state change, but a start pulse due from ST_LOAD in the same cycle still goes out
  always_comb
  begin
    next_state           = state;
    next_grp             = grp;
    next_motion_start    = 1'b0;
    next_motion_group    = motion_group;
    next_motion_relative = motion_relative;
    case (state)
      ST_IDLE:
        if (start_req && !stop_req)
        begin
          next_state = ST_LOAD;
          next_grp   = '0;
        end
      ST_LOAD:
        // R8: kind selects motion
        if (cfg[grp].kind == KIND_ABSOLUTE || cfg[grp].kind == KIND_RELATIVE)
        begin
          next_motion_start    = 1'b1;
          next_motion_group    = grp;
          next_motion_relative = (cfg[grp].kind == KIND_RELATIVE);
          next_state           = ST_WAIT;
        end
        else
          next_state = ST_IDLE;  // Unused group ends the run
      ST_WAIT:
        // R9: advance on condition
        if (cond_met)
        begin
          if (grp == GROUP_W'(NUM_GROUPS - 1))
            next_state = ST_IDLE;
          else
          begin
            next_grp   = grp + 1'b1;
            next_state = ST_LOAD;
          end
        end
      default: next_state = ST_IDLE;
    endcase
    if (stop_req)
      next_state = ST_IDLE;
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      state           <= ST_IDLE;
      grp             <= '0;
      motion_start    <= 1'b0;
      motion_group    <= '0;
      motion_relative <= 1'b0;
    end
    else
    begin
      state           <= next_state;
      grp             <= next_grp;
      motion_start    <= next_motion_start;
      motion_group    <= next_motion_group;
      motion_relative <= next_motion_relative;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  AST_KIND: assert property (@(posedge sys_clk) disable iff (reset)  // R8
    state == ST_LOAD && !stop_req
    |=> motion_start == ($past(cfg[grp].kind) != KIND_UNUSED && $past(cfg[grp].kind) != 2'h3)
        && (!motion_start || motion_relative == ($past(cfg[grp].kind) == KIND_RELATIVE)))
    else $error("Group kind not honoured");
  AST_ADVANCE: assert property (@(posedge sys_clk) disable iff (reset)  // R9
    state == ST_WAIT && cond_met && !stop_req && grp != GROUP_W'(NUM_GROUPS - 1)
    |=> state == ST_LOAD && grp == $past(grp) + 1'b1)
    else $error("Sequencer did not advance");

endmodule // motion_step_trigger

// >>> dv/step_input_model.sv
// Purpose: Partner model of the controller that drives the step input
// Assumes: Level commands come from the bench on sys_clk
// Notes:   lag delays each change to mimic a slow switch

`timescale 1ns/1ps

module step_input_model (
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic       level_cmd,           // Wanted pin level
  input  wire logic [3:0] lag,                 // Cycles before it follows
  output logic            position_step_input  // Push-pull, never floats
);
  logic [3:0] cnt;  // Cycles the command has waited

  // Follow the command after lag cycles, one clean step each time
  always_ff @(posedge sys_clk or posedge reset)
    if (reset) begin position_step_input <= 1'b0; cnt <= 4'h0; end
    else if (level_cmd == position_step_input) cnt <= 4'h0;
    else if (cnt >= lag) begin position_step_input <= level_cmd; cnt <= 4'h0; end
    else cnt <= cnt + 4'h1;
endmodule // step_input_model

// >>> dv/tb_motion_step_trigger.sv
// Purpose: Self-checking bench for the step trigger sequencer
// Assumes: TICK_CYCLES_P of 4, so one delay unit is 4 cycles
// Notes:   Group 1 is relative and unconditional, group 2 unused

`timescale 1ns/1ps

module tb_motion_step_trigger;
  import motion_step_pkg::*;
  localparam int TK = 4;  // Short delay unit keeps runs brief
  logic sys_clk = 0, reset = 1, lvl = 0;
  logic [3:0] lag = 4'h0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, motion_group, rsp;
  logic position_step_input, motion_start, motion_relative;
  logic [2:0] gr[32];  // Relative flag and group of each start
  int sc[32];          // Cycle of each start
  int miscompares = 0, num_checks = 0, cyc = 0, starts = 0;

  motion_step_trigger #(.TICK_CYCLES_P(TK)) dut_u (.*);
  step_input_model model_u (.sys_clk(sys_clk), .reset(reset), .level_cmd(lvl), .lag(lag),
                            .position_step_input(position_step_input));

  always #2 sys_clk = ~sys_clk;

  // Log every start pulse; cut a hang short
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (motion_start) begin gr[starts] <= {motion_relative, motion_group}; sc[starts] <= cyc; starts <= starts + 1; end
    if (cyc == 20000) begin miscompares++; end_sim(); end
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin miscompares++; $display("Error %s expected %h seen %h", nm, exp, seen); end
  endtask

  task automatic end_sim();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Handshakes sampled at the falling edge, where they have settled
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic pa, pw, ta, tw, tb;
    pa = 1; pw = 1;
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1; s_axi_wvalid <= 1;
    while (pa || pw) begin
      @(negedge sys_clk); ta = pa && s_axi_awready; tw = pw && s_axi_wready;
      @(posedge sys_clk);
      if (ta) begin pa = 0; s_axi_awvalid <= 0; end
      if (tw) begin pw = 0; s_axi_wvalid <= 0; end
    end
    s_axi_bready <= 1;
    do begin @(negedge sys_clk); tb = s_axi_bvalid; r = s_axi_bresp; @(posedge sys_clk); end while (!tb);
    s_axi_bready <= 0;
  endtask

  task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic t;
    s_axi_araddr <= a; s_axi_arvalid <= 1;
    do begin @(negedge sys_clk); t = s_axi_arready; @(posedge sys_clk); end while (!t);
    s_axi_arvalid <= 0;
    s_axi_rready <= 1;
    do begin @(negedge sys_clk); t = s_axi_rvalid; d = s_axi_rdata; r = s_axi_rresp; @(posedge sys_clk); end while (!t);
    s_axi_rready <= 0;
  endtask

  function automatic logic [7:0] ga(input logic [7:0] g, input logic [1:0] w);
    return GROUP_BASE + GROUP_STRIDE * g + {4'h0, w, 2'b00};
  endfunction

  task automatic cfg(input logic [7:0] g, input logic [1:0] k, input logic [3:0] t, input logic [15:0] v);
    wr(ga(g, KIND_WORD), {30'h0, k}, rsp);
    wr(ga(g, PROP_WORD), {28'h0, t}, rsp);
    wr(ga(g, VALUE_WORD), {16'h0, v}, rsp);
  endtask

  // Group 0 holds the condition; levels a before start, b must not fire, c fires
  task automatic trial(input logic [3:0] t, input logic [15:0] v, input logic a, b, c, input int gap);
    int s0;
    cfg(8'h0, KIND_ABSOLUTE, t, v);
    lvl <= a;
    repeat (20) @(posedge sys_clk);
    s0 = starts;
    wr(CTRL_OFS, 32'h1, rsp);
    repeat (4) @(posedge sys_clk);
    lvl <= b;
    repeat (40) @(posedge sys_clk);
    if (gap > 0) check("step_gap", sc[s0 + 1] - sc[s0], gap);
    else begin check("held_off", starts - s0, 1); lvl <= c; repeat (30) @(posedge sys_clk); end
    check("starts", starts - s0, 2);
    check("first_group", gr[s0], 3'b000);
    check("next_group", gr[s0 + 1], 3'b101);
    rdr(STATUS_OFS, rd, rsp);
    check("busy", rd[STATUS_BUSY_BIT], 1'b0);
  endtask

  initial begin
    repeat (8) @(posedge sys_clk);
    reset <= 0;
    @(posedge sys_clk);
    for (int w = 0; w < 3; w++) begin rdr(ga(8'h2, w[1:0]), rd, rsp); check("grp_reset", rd, 32'h0); end
    rdr(ga(8'h0, 2'h3), rd, rsp);
    check("unmapped_resp", rsp, RESP_SLVERR);
    check("unmapped_data", rd, 32'h0);
    wr(STATUS_OFS, 32'h1, rsp);
    check("status_wr", rsp, RESP_SLVERR);
    cfg(8'h1, KIND_RELATIVE, COND_UNCOND, 16'h0);
    rdr(ga(8'h1, KIND_WORD), rd, rsp);
    check("kind_back", rd, {30'h0, KIND_RELATIVE});
    check("read_resp", rsp, RESP_OKAY);
    trial(COND_UNCOND, 16'h0007, 0, 0, 0, 2);
    trial(COND_DELAY, 16'h0000, 0, 0, 0, 2);
    trial(COND_DELAY, 16'h0005, 0, 0, 0, 5 * TK + 2);
    trial(COND_EDGE, EDGE_RISE, 1, 0, 1, 0);
    lag <= 4'h5;
    trial(COND_EDGE, EDGE_FALL, 0, 1, 0, 0);
    trial(COND_EDGE, EDGE_BOTH, 0, 0, 1, 0);
    lag <= 4'h0;
    trial(COND_EDGE, EDGE_BOTH, 1, 1, 0, 0);
    trial(COND_LEVEL, LEVEL_HIGH, 0, 0, 1, 0);
    trial(COND_LEVEL, LEVEL_LOW, 1, 1, 0, 0);
    cfg(8'h0, KIND_ABSOLUTE, COND_LEVEL, LEVEL_HIGH);
    begin
      int s0;
      s0 = starts;
      wr(CTRL_OFS, 32'h1, rsp);
      repeat (10) @(posedge sys_clk);
      rdr(STATUS_OFS, rd, rsp);
      check("running", rd[STATUS_BUSY_BIT], 1'b1);
      wr(CTRL_OFS, 32'h2, rsp);
      check("stop_resp", rsp, RESP_OKAY);
      rdr(STATUS_OFS, rd, rsp);
      check("stopped", rd[STATUS_BUSY_BIT], 1'b0);
      lvl <= 1;
      repeat (20) @(posedge sys_clk);
      check("stop_held", starts - s0, 1);
      cfg(8'h0, KIND_UNUSED, COND_UNCOND, 16'h0);
      s0 = starts;
      wr(CTRL_OFS, 32'h1, rsp);
      repeat (20) @(posedge sys_clk);
      check("unused_start", starts - s0, 0);
    end
    end_sim();
  end
endmodule // tb_motion_step_trigger
